// *** dv/otpc_ctrl_assertions.sv ***
`timescale 1ns/10ps
`include "otpc_regs.vh"
// ****************
// Pin-level checks of the controller
// ****************
module otpc_ctrl_assertions #(
  parameter NDEV = 1
) (
  input wire CLK_IN,
  input wire RESET_N_IN,
  input wire CMD_VALID_IN,
  input wire [1:0] CMD_OP_IN,
  input wire CMD_READY_OUT,
  input wire RESP_VALID_OUT,
  input wire RESP_LAST_OUT,
  input wire [`OTPC_ADDR_W-1:0] ADDRESS_LINES_OUT,
  input wire DATA_LINES_OE_OUT,
  input wire [NDEV-1:0] CHIP_EN_N_OUT,
  input wire OUT_GATE_N_OUT,
  input wire PROGRAM_STROBE_N_OUT,
  input wire ID_SELECT_HV_OUT,
  input wire [1:0] VCC_SEL_OUT,
  input wire [1:0] VPP_SEL_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  wire ce = !CHIP_EN_N_OUT[0]; // Device 0 selected
  wire rd_on = ce && !OUT_GATE_N_OUT; // Device may drive the lines
  int pulse_cnt_r; // Length of the current program pulse
  // Counts cycles of chip enable low with strobe low
  always @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) pulse_cnt_r <= 0;
    else if (ce && !PROGRAM_STROBE_N_OUT) pulse_cnt_r <= pulse_cnt_r + 1;
    else pulse_cnt_r <= 0;
  end
  property p_no_fight; rd_on |-> !DATA_LINES_OE_OUT; endproperty
  a_no_fight: assert property (p_no_fight) else $error("host drives into read");
  property p_prog; ce && !PROGRAM_STROBE_N_OUT |->
    VPP_SEL_OUT == `OTPC_VPP_PROG && OUT_GATE_N_OUT && DATA_LINES_OE_OUT; endproperty
  a_prog: assert property (p_prog) else $error("bad program levels");
  property p_vcc; ce && !PROGRAM_STROBE_N_OUT |-> VCC_SEL_OUT == `OTPC_VCC_PROG; endproperty
  a_vcc: assert property (p_vcc) else $error("pulse without raised supply");
  property p_width; $rose(CHIP_EN_N_OUT[0]) && !PROGRAM_STROBE_N_OUT |->
    pulse_cnt_r >= 1000 && pulse_cnt_r <= 5000; endproperty
  a_width: assert property (p_width) else $error("pulse width out of window");
  property p_vfy; rd_on && VPP_SEL_OUT == `OTPC_VPP_PROG |-> PROGRAM_STROBE_N_OUT; endproperty
  a_vfy: assert property (p_vfy) else $error("verify with strobe low");
  property p_id; ID_SELECT_HV_OUT |-> ADDRESS_LINES_OUT[16:2] == 0; endproperty
  a_id: assert property (p_id) else $error("address high during id");
  property p_final; rd_on && VCC_SEL_OUT == `OTPC_VCC_VFY |->
    VPP_SEL_OUT == `OTPC_VPP_VFY; endproperty
  a_final: assert property (p_final) else $error("final read supplies differ");
  property p_idle; CMD_READY_OUT |-> &CHIP_EN_N_OUT && OUT_GATE_N_OUT && !DATA_LINES_OE_OUT;
  endproperty
  a_idle: assert property (p_idle) else $error("idle not in standby");
  property p_rd; CMD_VALID_IN && CMD_READY_OUT && CMD_OP_IN == `OTPC_OP_READ |->
    ##[107:109] RESP_VALID_OUT && RESP_LAST_OUT; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
endmodule

// *** dv/otpc_dev_model.sv ***
`timescale 1ns/10ps
`include "otpc_regs.vh"
// ****************
// Behavioural one-time-programmable byte memory
// ****************
module otpc_dev_model #(
  parameter [7:0] MFR = 8'h2A, // Arbitrary maker code, odd parity
  parameter [7:0] DEV = 8'h0B, // Arbitrary device code, odd parity
  parameter [7:0] CONT = 8'h55 // Arbitrary continuation code
) (
  input wire [16:0] addr_in,
  input wire [7:0] din_in,
  input wire ce_n_in,
  input wire oe_n_in,
  input wire pgm_n_in,
  input wire hv_in,
  input wire [1:0] vpp_in,
  input int need_in,
  output logic [7:0] dq_out
);
  logic [7:0] mem [int]; // Sparse 128K x 8 array
  int hits [int]; // Pulses seen per address, weak cells need several
  logic [7:0] last = 8'h00;
  int gen = 0;
  wire drv = !ce_n_in && !oe_n_in;
  function automatic logic [7:0] rd(int a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  // Released lines show the inverse, so a stale sample never passes
  always @(drv or hv_in or addr_in or last or gen) begin
    if (!drv) dq_out = ~last;
    else if (hv_in) dq_out = !addr_in[1] ? CONT : (addr_in[0] ? DEV : MFR);
    else dq_out = rd(addr_in);
  end
  always @(dq_out) if (drv) last = dq_out;
  // Pulse ends at chip enable rise; only ones can be cleared
  always @(posedge ce_n_in) begin
    if (!pgm_n_in && oe_n_in && vpp_in == `OTPC_VPP_PROG) begin
      hits[addr_in] = hits.exists(addr_in) ? hits[addr_in] + 1 : 1;
      if (hits[addr_in] >= need_in) begin
        mem[addr_in] = rd(addr_in) & din_in;
        hits.delete(addr_in);
        gen++;
      end
    end
  end
endmodule

// *** dv/test_otp_byte_memory_modes.sv ***
`timescale 1ns/10ps
`include "otpc_regs.vh"
module test_otp_byte_memory_modes;
  localparam [7:0] MFR = 8'h2A, DEV = 8'h0B, CONT = 8'h55;
  logic clk = 0, rst_n = 0, vld = 0, dv = 0;
  logic [1:0] op = 0;
  logic [16:0] ad = 0;
  logic [7:0] dt = 0;
  wire rdy, rv, rerr, rlast, oe, cen, gn, pgn, hv;
  wire [7:0] rdat, dout, ddq, dqi;
  wire [16:0] radr, pa;
  wire [1:0] vcc, vpp;
  int need = 1, err_count = 0, compares = 0, cyc = 0;
  logic [7:0] ref_mem [int]; // Expected array contents
  logic [25:0] exp_q [$]; // {error, address, data} per response
  assign dqi = oe ? dout : ddq;
  always #10 clk = ~clk;
  otpc_ctrl #(.MAX_PULSES(3)) dut_u (.CLK_IN(clk), .RESET_N_IN(rst_n), .CMD_VALID_IN(vld),
    .CMD_OP_IN(op), .CMD_ADDR_IN(ad), .CMD_DATA_IN(dt), .CMD_DEV_IN(dv), .CMD_READY_OUT(rdy),
    .RESP_VALID_OUT(rv), .RESP_DATA_OUT(rdat), .RESP_ADDR_OUT(radr), .RESP_ERROR_OUT(rerr),
    .RESP_LAST_OUT(rlast), .ADDRESS_LINES_OUT(pa), .DATA_LINES_IN(dqi), .DATA_LINES_OUT(dout),
    .DATA_LINES_OE_OUT(oe), .CHIP_EN_N_OUT(cen), .OUT_GATE_N_OUT(gn),
    .PROGRAM_STROBE_N_OUT(pgn), .ID_SELECT_HV_OUT(hv), .VCC_SEL_OUT(vcc), .VPP_SEL_OUT(vpp));
  otpc_dev_model #(.MFR(MFR), .DEV(DEV), .CONT(CONT)) dev_u (.addr_in(pa), .din_in(dout),
    .ce_n_in(cen), .oe_n_in(gn), .pgm_n_in(pgn), .hv_in(hv), .vpp_in(vpp), .need_in(need),
    .dq_out(ddq));
  task automatic stop_test;
    $display("Checks %0d, errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] refv(int a);
    return ref_mem.exists(a) ? ref_mem[a] : 8'hFF;
  endfunction
  // One command, then every response checked against the queue
  task automatic cmd(input logic [1:0] o, input logic [16:0] a, input logic [7:0] d);
    int i;
    i = 0;
    do begin @(posedge clk); i++; end while (rdy !== 1'b1 && i < 3000);
    if (rdy !== 1'b1) chk(0, 1);
    op <= o; ad <= a; dt <= d; vld <= 1;
    @(posedge clk);
    vld <= 0;
    for (i = 0; i < 6000; i++) begin
      @(posedge clk);
      if (rv === 1'b1) begin
        chk({rerr, radr, rdat}, exp_q.pop_front());
        chk(rlast, exp_q.size() == 0);
        if (rlast === 1'b1) break;
      end
    end
    if (i == 6000) chk(0, 1);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      stop_test;
    end
  end
  initial begin
    int a, k;
    logic [7:0] d, old;
    int needs [5];
    void'($urandom(32'h37DE));
    needs = '{1, 2, 3, 5, 2};
    repeat (12) @(posedge clk);
    rst_n <= 1;
    // Blank byte at 4 to 1003, above the programmed ones
    a = 4 + $urandom % 1000;
    exp_q.push_back({1'b0, a[16:0], 8'hFF});
    cmd(`OTPC_OP_READ, a, 8'h00);
    // Pulse counts below, at and above the retry limit, then overprogram
    for (k = 0; k < 5; k++) begin
      a = k % 4;
      d = $urandom;
      need = needs[k];
      old = refv(a);
      if (need <= 3) ref_mem[a] = old & d;
      // Zeros never turn back to ones, so a byte asking for a one over a zero fails
      exp_q.push_back({(need > 3) || ((old & d) != d), a[16:0], refv(a)});
      cmd(`OTPC_OP_PROG, a, d);
    end
    // All four identification places
    for (k = 0; k < 4; k++) begin
      exp_q.push_back({1'b0, k[16:0], k[1] ? (k[0] ? DEV : MFR) : CONT});
      cmd(`OTPC_OP_ID, k, 8'h00);
    end
    // Whole-array readback of the programmed span
    for (k = 0; k < 4; k++) exp_q.push_back({1'b0, k[16:0], refv(k)});
    cmd(`OTPC_OP_FINAL, 17'h00003, 8'h00);
    stop_test;
  end
endmodule
bind otpc_ctrl otpc_ctrl_assertions #(.NDEV(NDEV)) chk_u (.CLK_IN, .RESET_N_IN, .CMD_VALID_IN,
  .CMD_OP_IN, .CMD_READY_OUT, .RESP_VALID_OUT, .RESP_LAST_OUT, .ADDRESS_LINES_OUT,
  .DATA_LINES_OE_OUT, .CHIP_EN_N_OUT, .OUT_GATE_N_OUT, .PROGRAM_STROBE_N_OUT,
  .ID_SELECT_HV_OUT, .VCC_SEL_OUT, .VPP_SEL_OUT);

// *** include/otpc_regs.vh ***
`ifndef OTPC_REGS_VH
`define OTPC_REGS_VH

// ****************************************************************
// Clock and timing figures
// ****************************************************************
`define OTPC_CLK_NS 20
// Program pulse width in ns, legal window 20 us to 100 us
`define OTPC_PULSE_NS 20000
// Supply ramp settling time in ns before the pins are used
`define OTPC_SETTLE_NS 2000
// Worst read access time of the part in ns
`define OTPC_ACCESS_NS 90
// Least time in ns with all strobes idle between pulse and verify
`define OTPC_RECOV_NS 40
// Cycle counts, least times rounded up
`define OTPC_CYC_UP(ns) (((ns) + `OTPC_CLK_NS - 1) / `OTPC_CLK_NS)
// Default retry limit for pulse-and-verify
`define OTPC_MAX_PULSES 25

// ****************************************************************
// Command opcodes
// ****************************************************************
`define OTPC_OP_READ 2'h0
`define OTPC_OP_PROG 2'h1
`define OTPC_OP_ID 2'h2
`define OTPC_OP_FINAL 2'h3

// ****************************************************************
// Supply selects, one code per level
// ****************************************************************
`define OTPC_VCC_NOM 2'h0
`define OTPC_VCC_PROG 2'h1
`define OTPC_VCC_VFY 2'h2
`define OTPC_VPP_READ 2'h0
`define OTPC_VPP_PROG 2'h1
`define OTPC_VPP_VFY 2'h2

// ****************************************************************
// Array shape and identification layout
// ****************************************************************
`define OTPC_ADDR_W 17
`define OTPC_DATA_W 8
`define OTPC_ID_BYTE_BIT 0
`define OTPC_ID_BANK_BIT 1

`endif

// *** verilog/otpc_ctrl.v ***
`timescale 1ns/10ps
`include "otpc_regs.vh"
// What this block does
// RULE1: 17 address lines, 8 data lines per word
// RULE2: blank bits read one; programming clears only
// RULE3: program mode: VPP high, gate high, enables low
// RULE4: programmer drives all eight data lines together
// RULE5: program pulses last 20 to 100 us
// RULE6: verify after each pulse, retry to limit
// RULE7: loop each address with VCC at 6.25V
// RULE8: final whole-array readback at 5.25V supplies
// RULE9: per-device chip enable pulse selects programming
// RULE10: chip enable high with VPP inhibits programming
// RULE11: verify: gate, enable low, strobe high, VPP
// RULE12: identification needs 12V on select line
// RULE13: other address lines low during identification
// RULE14: bank high: byte select picks maker/device
// RULE15: identification bytes carry odd parity bit
// RULE16: bank low gives continuation code always
// RULE17: device drives only with enable and gate
// RULE18: chip enable high means standby, high-Z
// RULE19: enable selects device, gate gates data
// RULE20: enable low, gate high: lines are inputs
module otpc_ctrl #(
  parameter NDEV = 1,
  parameter DEVW = 1,
  parameter MAX_PULSES = `OTPC_MAX_PULSES,
  parameter PULSE_NS = `OTPC_PULSE_NS
) (
  input wire CLK_IN,
  input wire RESET_N_IN,
  // User command side
  input wire CMD_VALID_IN,
  input wire [1:0] CMD_OP_IN,
  input wire [`OTPC_ADDR_W-1:0] CMD_ADDR_IN,
  input wire [`OTPC_DATA_W-1:0] CMD_DATA_IN,
  input wire [DEVW-1:0] CMD_DEV_IN,
  output reg CMD_READY_OUT,
  output reg RESP_VALID_OUT,
  output reg [`OTPC_DATA_W-1:0] RESP_DATA_OUT,
  output reg [`OTPC_ADDR_W-1:0] RESP_ADDR_OUT,
  output reg RESP_ERROR_OUT,
  output reg RESP_LAST_OUT,
  // Device pins
  output reg [`OTPC_ADDR_W-1:0] ADDRESS_LINES_OUT,
  input wire [`OTPC_DATA_W-1:0] DATA_LINES_IN,
  output reg [`OTPC_DATA_W-1:0] DATA_LINES_OUT,
  output reg DATA_LINES_OE_OUT,
  output reg [NDEV-1:0] CHIP_EN_N_OUT,
  output reg OUT_GATE_N_OUT,
  output reg PROGRAM_STROBE_N_OUT,
  output reg ID_SELECT_HV_OUT,
  output reg [1:0] VCC_SEL_OUT,
  output reg [1:0] VPP_SEL_OUT
);
  // ****************************************************************
  // Constants
  // ****************************************************************
  // Integer forms first, then cut to the counter widths on purpose
  localparam integer PULSE_I = `OTPC_CYC_UP(PULSE_NS);
  localparam integer SETTLE_I = `OTPC_CYC_UP(`OTPC_SETTLE_NS);
  // Access time plus the two synchroniser stages
  localparam integer ACCESS_I = `OTPC_CYC_UP(`OTPC_ACCESS_NS) + 2;
  localparam integer RECOV_I = `OTPC_CYC_UP(`OTPC_RECOV_NS);
  localparam integer MAX_I = MAX_PULSES;
  localparam [15:0] PULSE_CYC = PULSE_I[15:0];
  localparam [15:0] SETTLE_CYC = SETTLE_I[15:0];
  localparam [15:0] ACCESS_CYC = ACCESS_I[15:0];
  localparam [15:0] RECOV_CYC = RECOV_I[15:0];
  localparam [7:0] MAX_P = MAX_I[7:0];

  localparam [2:0] S_IDLE = 3'h0; // Ready for a command
  localparam [2:0] S_SETTLE = 3'h1; // Supplies ramping up
  localparam [2:0] S_PULSE = 3'h2; // Program pulse on chip enable
  localparam [2:0] S_RECOV = 3'h3; // All strobes idle
  localparam [2:0] S_VFY = 3'h4; // Verify or plain read access
  localparam [2:0] S_DOWN = 3'h5; // Supplies ramping back

  // ****************************************************************
  // State
  // ****************************************************************
  reg [2:0] state_r; // Sequencer state
  reg [15:0] cnt_r; // Cycle counter within a state
  reg [7:0] pulses_r; // Pulses given to the current address
  reg [1:0] op_r; // Latched opcode
  reg [`OTPC_ADDR_W-1:0] last_r; // Last address of a final verify
  reg [`OTPC_DATA_W-1:0] wdata_r; // Byte to program
  reg [DEVW-1:0] dev_r; // Selected device
  wire [`OTPC_DATA_W-1:0] rd_sync; // Data pins after two flops

  otpc_sync #(.W(`OTPC_DATA_W)) u_sync (
    .CLK_IN(CLK_IN),
    .RESET_N_IN(RESET_N_IN),
    .D_IN(DATA_LINES_IN),
    .Q_OUT(rd_sync)
  );

  // Active-low enable vector with only the chosen device low
  function [NDEV-1:0] ce_sel;
    input [DEVW-1:0] dev;
    integer i;
    begin
      for (i = 0; i < NDEV; i = i + 1) begin
        ce_sel[i] = (dev != i[DEVW-1:0]);
      end
    end
  endfunction

  // Even weight on a maker or device byte (bank high) means a broken read
  function id_bad;
    input [`OTPC_DATA_W-1:0] b;
    begin
      id_bad = ~(^b); // RULE15
    end
  endfunction

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // One process keeps every pin output on a flip-flop
  always @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_r <= S_IDLE;
      cnt_r <= 16'h0000;
      pulses_r <= 8'h00;
      op_r <= `OTPC_OP_READ;
      last_r <= {`OTPC_ADDR_W{1'b0}};
      wdata_r <= {`OTPC_DATA_W{1'b1}};
      dev_r <= {DEVW{1'b0}};
      CMD_READY_OUT <= 1'b0;
      RESP_VALID_OUT <= 1'b0;
      RESP_DATA_OUT <= {`OTPC_DATA_W{1'b0}};
      RESP_ADDR_OUT <= {`OTPC_ADDR_W{1'b0}};
      RESP_ERROR_OUT <= 1'b0;
      RESP_LAST_OUT <= 1'b0;
      ADDRESS_LINES_OUT <= {`OTPC_ADDR_W{1'b0}};
      DATA_LINES_OUT <= {`OTPC_DATA_W{1'b0}};
      DATA_LINES_OE_OUT <= 1'b0;
      CHIP_EN_N_OUT <= {NDEV{1'b1}};
      OUT_GATE_N_OUT <= 1'b1;
      PROGRAM_STROBE_N_OUT <= 1'b1;
      ID_SELECT_HV_OUT <= 1'b0;
      VCC_SEL_OUT <= `OTPC_VCC_NOM;
      VPP_SEL_OUT <= `OTPC_VPP_READ;
    end else begin
      RESP_VALID_OUT <= 1'b0;
      RESP_LAST_OUT <= 1'b0;
      cnt_r <= cnt_r + 16'h0001;
      case (state_r)
        S_IDLE: begin
          // Parts deselected so every data line is high-Z
          CHIP_EN_N_OUT <= {NDEV{1'b1}}; // RULE18
          CMD_READY_OUT <= 1'b1;
          cnt_r <= 16'h0000;
          if (CMD_VALID_IN && CMD_READY_OUT) begin
            CMD_READY_OUT <= 1'b0;
            op_r <= CMD_OP_IN;
            wdata_r <= CMD_DATA_IN;
            dev_r <= CMD_DEV_IN;
            last_r <= CMD_ADDR_IN;
            pulses_r <= 8'h00;
            state_r <= S_SETTLE;
            ADDRESS_LINES_OUT <= CMD_ADDR_IN; // RULE1
            case (CMD_OP_IN)
              `OTPC_OP_PROG: begin
                VCC_SEL_OUT <= `OTPC_VCC_PROG; // RULE7
                VPP_SEL_OUT <= `OTPC_VPP_PROG; // RULE3
              end
              `OTPC_OP_FINAL: begin
                VCC_SEL_OUT <= `OTPC_VCC_VFY; // RULE8
                VPP_SEL_OUT <= `OTPC_VPP_VFY; // RULE8
                ADDRESS_LINES_OUT <= {`OTPC_ADDR_W{1'b0}};
              end
              `OTPC_OP_ID: begin
                // Only byte select and bank may be high
                ADDRESS_LINES_OUT <= {`OTPC_ADDR_W{1'b0}}; // RULE13
                ADDRESS_LINES_OUT[`OTPC_ID_BYTE_BIT] <=
                  CMD_ADDR_IN[`OTPC_ID_BYTE_BIT]; // RULE14
                ADDRESS_LINES_OUT[`OTPC_ID_BANK_BIT] <=
                  CMD_ADDR_IN[`OTPC_ID_BANK_BIT]; // RULE16
                ID_SELECT_HV_OUT <= 1'b1; // RULE12
              end
              default: begin
                VCC_SEL_OUT <= `OTPC_VCC_NOM;
                VPP_SEL_OUT <= `OTPC_VPP_READ;
              end
            endcase
          end
        end
        S_SETTLE: begin
          // Wait out the supply ramp before touching strobes
          if (cnt_r == SETTLE_CYC - 16'h0001) begin
            cnt_r <= 16'h0000;
            if (op_r == `OTPC_OP_PROG) begin
              state_r <= S_PULSE;
              OUT_GATE_N_OUT <= 1'b1; // RULE20
              PROGRAM_STROBE_N_OUT <= 1'b0; // RULE9
              DATA_LINES_OUT <= wdata_r; // RULE4
              DATA_LINES_OE_OUT <= 1'b1; // RULE4
            end else begin
              state_r <= S_VFY;
              CHIP_EN_N_OUT <= ce_sel(dev_r); // RULE19
              OUT_GATE_N_OUT <= 1'b0; // RULE17
            end
          end
        end
        S_PULSE: begin
          // Only the selected part sees the low enable pulse;
          // the others sit inhibited with VPP applied
          CHIP_EN_N_OUT <= ce_sel(dev_r); // RULE9 RULE10
          // Enable falls at count 0 and rises at PULSE_CYC, so the pulse
          // lasts the full PULSE_CYC cycles and is never a cycle short
          if (cnt_r == PULSE_CYC) begin
            CHIP_EN_N_OUT <= {NDEV{1'b1}}; // RULE5
            pulses_r <= pulses_r + 8'h01;
            cnt_r <= 16'h0000;
            state_r <= S_RECOV;
          end
        end
        S_RECOV: begin
          // Drop our drivers before the part may drive back
          DATA_LINES_OE_OUT <= 1'b0;
          PROGRAM_STROBE_N_OUT <= 1'b1;
          if (cnt_r == RECOV_CYC - 16'h0001) begin
            cnt_r <= 16'h0000;
            state_r <= S_VFY;
            CHIP_EN_N_OUT <= ce_sel(dev_r); // RULE11
            OUT_GATE_N_OUT <= 1'b0; // RULE11
          end
        end
        S_VFY: begin
          if (cnt_r == ACCESS_CYC - 16'h0001) begin
            cnt_r <= 16'h0000;
            if (op_r == `OTPC_OP_PROG) begin
              if (rd_sync == wdata_r) begin
                // Byte took, stop pulsing this address
                RESP_VALID_OUT <= 1'b1; // RULE6
                RESP_ERROR_OUT <= 1'b0;
                RESP_LAST_OUT <= 1'b1;
                RESP_DATA_OUT <= rd_sync;
                RESP_ADDR_OUT <= ADDRESS_LINES_OUT;
                state_r <= S_DOWN;
              end else if (pulses_r >= MAX_P) begin
                // Retry limit hit, report failure
                RESP_VALID_OUT <= 1'b1; // RULE6
                RESP_ERROR_OUT <= 1'b1;
                RESP_LAST_OUT <= 1'b1;
                RESP_DATA_OUT <= rd_sync;
                RESP_ADDR_OUT <= ADDRESS_LINES_OUT;
                state_r <= S_DOWN;
              end else begin
                // Park with every strobe idle before the next pulse; raising
                // our drivers on the edge that ends the read would fight the part
                state_r <= S_SETTLE; // RULE6
              end
              CHIP_EN_N_OUT <= {NDEV{1'b1}};
              OUT_GATE_N_OUT <= 1'b1;
            end else begin
              RESP_VALID_OUT <= 1'b1;
              RESP_DATA_OUT <= rd_sync;
              RESP_ADDR_OUT <= ADDRESS_LINES_OUT;
              RESP_ERROR_OUT <= (op_r == `OTPC_OP_ID) &&
                ADDRESS_LINES_OUT[`OTPC_ID_BANK_BIT] && id_bad(rd_sync);
              if (op_r == `OTPC_OP_FINAL && ADDRESS_LINES_OUT != last_r) begin
                // Walk the array, one byte per access time
                ADDRESS_LINES_OUT <= ADDRESS_LINES_OUT +
                  {{(`OTPC_ADDR_W-1){1'b0}}, 1'b1}; // RULE8
              end else begin
                RESP_LAST_OUT <= 1'b1;
                CHIP_EN_N_OUT <= {NDEV{1'b1}};
                OUT_GATE_N_OUT <= 1'b1;
                state_r <= S_DOWN;
              end
            end
          end
        end
        S_DOWN: begin
          // Return to read supplies and let them settle
          ID_SELECT_HV_OUT <= 1'b0;
          VCC_SEL_OUT <= `OTPC_VCC_NOM;
          VPP_SEL_OUT <= `OTPC_VPP_READ;
          DATA_LINES_OE_OUT <= 1'b0;
          PROGRAM_STROBE_N_OUT <= 1'b1;
          if (cnt_r == SETTLE_CYC - 16'h0001) begin
            cnt_r <= 16'h0000;
            state_r <= S_IDLE;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// *** verilog/otpc_sync.v ***
`timescale 1ns/10ps
// ****************************************************************
// Two-stage synchroniser for the data pins
// ****************************************************************
module otpc_sync #(
  parameter W = 8
) (
  input wire CLK_IN,
  input wire RESET_N_IN,
  input wire [W-1:0] D_IN,
  output reg [W-1:0] Q_OUT
);
  reg [W-1:0] meta_r; // First stage, read only by the second

  // Pins change with no relation to our clock
  always @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      meta_r <= {W{1'b0}};
      Q_OUT <= {W{1'b0}};
    end else begin
      meta_r <= D_IN;
      Q_OUT <= meta_r;
    end
  end
endmodule
